// ### pmi_top.sv
`default_nettype none
`include "pmi_regs.svh"
// Overview of operation
// - Processor load overrides cell preset, clear, clock.
// - Cell flip-flops readable and writable in window.
// - Load on strobe trailing edge or level.
// - Per-group mask resets zero, blocks loads.
// - Pin driver enable is term OR direction.
// - Logic output without enable term drives always.
// - Internal node cell still feeds logic array.
// - Input cells latch, register or pass through.
// - Input clock: product term or address strobe.
// - Group term budgets: three/six, four/five/six.
// - Three byte ports and one 3-bit port.
// - Pin mux: data, address, cell, chip selects.
// - Read-back returns exactly one source at once.
// - Without term or logic output, direction decides.
// - Programmed modes static; control bits run-time.
// - Control zero gives processor I/O mode.
// - Ports C, D lack control register.
// - Address out when direction and control set.
// - Over-budget cells expand with extra delay.
// - Direction one is output, default input.
// - Configuration registers reset to zero.
// - External clock rising edge; set/clear active high.
module pmi_top (
   input  wire logic                   CORE_CLK,
   input  wire logic                   SYS_RST,
   input  wire logic                   BUS_SEL,
   input  wire logic [7:0]             BUS_ADDR,
   input  wire logic [7:0]             BUS_WDATA,
   input  wire logic                   BUS_WR_N,
   input  wire logic                   BUS_RD_N,
   input  wire logic                   BUS_ALE,
   input  wire logic [7:0]             BUS_ALAT,
   output logic      [7:0]             BUS_RDATA,
   input  wire logic                   CFG_LEVEL_LD,
   input  wire logic [26:0]            CFG_LOUT,
   input  wire logic [26:0]            CFG_OE_DEF,
   input  wire logic [7:0]             CFG_B_GRPB,
   input  wire logic [15:0]            CFG_COMB,
   input  wire logic [15:0]            CFG_EXTCLK,
   input  wire logic [63:0]            CFG_TERMS,
   input  wire pmi_pkg::pmi_imc_mode_t [23:0] CFG_IMC_MODE,
   input  wire logic [5:0]             CFG_IMC_ALE,
   input  wire logic [15:0]            LA_CELL_D,
   input  wire logic [15:0]            LA_CELL_CLK,
   input  wire logic [15:0]            LA_CELL_PRE,
   input  wire logic [15:0]            LA_CELL_CLR,
   input  wire logic                   LA_CLK_IN,
   input  wire logic [26:0]            LA_OE,
   input  wire logic [1:0]             LA_ECS,
   input  wire logic [5:0]             LA_IMC_PT,
   output logic      [15:0]            LA_CELL_FB,
   output logic      [23:0]            LA_IMC_OUT,
   output logic      [15:0]            CELL_EXPAND,
   input  wire logic [26:0]            PIN_IN,
   output logic      [26:0]            PIN_OUT,
   output logic      [26:0]            PIN_OE,
   output logic      [26:0]            PIN_DRV
);
   import pmi_pkg::*;
   pmi_top_st_t st;
   pmi_top_st_t nx;
   logic [15:0] ld;
   logic [15:0] cq;
   logic [15:0] cy;
   logic [15:0] xp;
   logic [23:0] imo;
   logic        wr_end;
   logic        cell_wr;
   logic        ext_rise;

   // ****************************************************************
   // Output cells
   // ****************************************************************
   // Sixteen cells; group a takes 3+6 terms, group b 4+5 or 4+6.
   for (genvar i = 0; i < 16; i++)
   begin : g_omc
      pmi_omc #(
         .NATIVE ((i < 8) ? `PMI_NAT_A : `PMI_NAT_B),
         .BORROW ((i < 8) ? `PMI_BOR_A : ((i < 12) ? `PMI_BOR_B_LO : `PMI_BOR_B_HI))
      ) u_omc (
         .clk      (CORE_CLK),
         .rst      (SYS_RST),
         .ld       (ld[i]),
         .ld_d     (BUS_WDATA[i % 8]),
         .d        (LA_CELL_D[i]),
         .pt_clk   (LA_CELL_CLK[i]),
         .ext_rise (ext_rise),
         .use_ext  (CFG_EXTCLK[i]),
         .pre      (LA_CELL_PRE[i]),
         .clr      (LA_CELL_CLR[i]),
         .comb     (CFG_COMB[i]),
         .terms    (CFG_TERMS[4*i +: 4]),
         .q        (cq[i]),
         .y        (cy[i]),
         .xp       (xp[i])
      );
   end

   // ****************************************************************
   // Input cells
   // ****************************************************************
   // One cell per pin of ports A to C, clocked per nibble.
   for (genvar k = 0; k < 6; k++)
   begin : g_imc
      pmi_imc #(
         .W (4)
      ) u_imc (
         .clk     (CORE_CLK),
         .rst     (SYS_RST),
         .mode    (CFG_IMC_MODE[4*k +: 4]),
         .pt      (LA_IMC_PT[k]),
         .ale     (BUS_ALE),
         .use_ale (CFG_IMC_ALE[k]),
         .pin     (PIN_IN[4*k +: 4]),
         .o       (imo[4*k +: 4])
      );
   end

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   // Register writes, cell loads, read-back and pin multiplexing.
   always_comb
   begin
      logic src;
      logic lo;
      src      = 1'b0;
      lo       = 1'b0;
      nx       = st;
      nx.wr_n_q = BUS_WR_N;
      nx.clk_q  = LA_CLK_IN;
      ext_rise = LA_CLK_IN & ~st.clk_q;
      wr_end   = BUS_SEL & ~st.wr_n_q & BUS_WR_N;
      cell_wr  = CFG_LEVEL_LD ? (BUS_SEL & ~BUS_WR_N) : wr_end;
      if (BUS_ALE)
         nx.alat = BUS_ALAT;
      // Processor load, gated by the mask.
      ld = '0;
      if (cell_wr && BUS_ADDR == `PMI_OFS_CELL_A)
         ld[7:0] = ~st.mask_a;
      if (cell_wr && BUS_ADDR == `PMI_OFS_CELL_B)
         ld[15:8] = ~st.mask_b;
      // Run-time registers, written at strobe end.
      if (wr_end)
      begin
         case (BUS_ADDR)
            `PMI_OFS_DOUT_A: nx.dout[7:0]   = BUS_WDATA;
            `PMI_OFS_DOUT_B: nx.dout[15:8]  = BUS_WDATA;
            `PMI_OFS_DOUT_C: nx.dout[23:16] = BUS_WDATA;
            `PMI_OFS_DOUT_D: nx.dout[26:24] = BUS_WDATA[2:0];
            `PMI_OFS_CTL_A:  nx.ctl[7:0]    = BUS_WDATA;
            `PMI_OFS_CTL_B:  nx.ctl[15:8]   = BUS_WDATA;
            `PMI_OFS_DIR_A:  nx.dir[7:0]    = BUS_WDATA;
            `PMI_OFS_DIR_B:  nx.dir[15:8]   = BUS_WDATA;
            `PMI_OFS_DIR_C:  nx.dir[23:16]  = BUS_WDATA;
            `PMI_OFS_DIR_D:  nx.dir[26:24]  = BUS_WDATA[2:0];
            `PMI_OFS_DRV_A:  nx.drv[7:0]    = BUS_WDATA;
            `PMI_OFS_DRV_B:  nx.drv[15:8]   = BUS_WDATA;
            `PMI_OFS_DRV_C:  nx.drv[23:16]  = BUS_WDATA;
            `PMI_OFS_DRV_D:  nx.drv[26:24]  = BUS_WDATA[2:0];
            `PMI_OFS_MASK_A: nx.mask_a      = BUS_WDATA;
            `PMI_OFS_MASK_B: nx.mask_b      = BUS_WDATA;
            default:         nx.mask_a      = st.mask_a; // Masked or unmapped: no change.
         endcase
      end
      // One source onto the read bus.
      nx.rdata = `PMI_RST_BYTE;
      if (BUS_SEL && !BUS_RD_N)
      begin
         // Cells read back; bit n is cell n, or cell 8+n for group b.
         case (BUS_ADDR)
            `PMI_OFS_DIN_A:  nx.rdata = PIN_IN[7:0];
            `PMI_OFS_DIN_B:  nx.rdata = PIN_IN[15:8];
            `PMI_OFS_DIN_C:  nx.rdata = PIN_IN[23:16];
            `PMI_OFS_DIN_D:  nx.rdata = {5'h00, PIN_IN[26:24]};
            `PMI_OFS_DOUT_A: nx.rdata = st.dout[7:0];
            `PMI_OFS_DOUT_B: nx.rdata = st.dout[15:8];
            `PMI_OFS_DOUT_C: nx.rdata = st.dout[23:16];
            `PMI_OFS_DOUT_D: nx.rdata = {5'h00, st.dout[26:24]};
            `PMI_OFS_CTL_A:  nx.rdata = st.ctl[7:0];
            `PMI_OFS_CTL_B:  nx.rdata = st.ctl[15:8];
            `PMI_OFS_DIR_A:  nx.rdata = st.dir[7:0];
            `PMI_OFS_DIR_B:  nx.rdata = st.dir[15:8];
            `PMI_OFS_DIR_C:  nx.rdata = st.dir[23:16];
            `PMI_OFS_DIR_D:  nx.rdata = {5'h00, st.dir[26:24]};
            `PMI_OFS_DRV_A:  nx.rdata = st.drv[7:0];
            `PMI_OFS_DRV_B:  nx.rdata = st.drv[15:8];
            `PMI_OFS_DRV_C:  nx.rdata = st.drv[23:16];
            `PMI_OFS_DRV_D:  nx.rdata = {5'h00, st.drv[26:24]};
            `PMI_OFS_CELL_A: nx.rdata = cq[7:0];
            `PMI_OFS_CELL_B: nx.rdata = cq[15:8];
            `PMI_OFS_MASK_A: nx.rdata = st.mask_a;
            `PMI_OFS_MASK_B: nx.rdata = st.mask_b;
            // Input cells readable by the processor.
            `PMI_OFS_IMC_A:  nx.rdata = imo[7:0];
            `PMI_OFS_IMC_B:  nx.rdata = imo[15:8];
            `PMI_OFS_IMC_C:  nx.rdata = imo[23:16];
            default:         nx.rdata = `PMI_RST_BYTE;
         endcase
      end
      for (int p = 0; p < 27; p++)
      begin
         src = st.dout[p];
         lo  = CFG_LOUT[p];
         if (p < 16 && st.ctl[p % 16])
            src = st.alat[p % 8];
         else if (p < 8 && lo)
            src = cy[p];
         else if (p < 16 && lo)
            src = CFG_B_GRPB[p % 8] ? cy[8 + (p % 8)] : cy[p % 8];
         else if (p < 24 && lo)
            // Port C has no control register.
            src = cy[8 + (p % 8)];
         else if (p >= 25 && lo)
            src = LA_ECS[p - 25];
         nx.pin_out[p] = src; // Otherwise data-out register.
         nx.pin_oe[p]  = st.dir[p] | (CFG_OE_DEF[p] ? LA_OE[p] : lo);
      end
      nx.drv_o = st.drv;
      nx.fb    = cy;
      nx.imc   = imo;
      nx.xp    = xp;
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   // Configuration registers clear at reset.
   always_ff @(posedge CORE_CLK)
   begin
      if (SYS_RST)
      begin
         st        <= '0;
         st.wr_n_q <= `PMI_WR_IDLE;
         st.pin_oe <= CFG_LOUT & ~CFG_OE_DEF;
      end
      else
         st <= nx;
   end

   // Outputs straight from the state register.
   assign BUS_RDATA   = st.rdata;
   assign PIN_OUT     = st.pin_out;
   assign PIN_OE      = st.pin_oe;
   assign PIN_DRV     = st.drv_o;
   assign LA_CELL_FB  = st.fb;
   assign LA_IMC_OUT  = st.imc;
   assign CELL_EXPAND = st.xp;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (SYS_RST);

   a_mask_reset_zero: assert property (disable iff (1'b0)
      SYS_RST ##1 !SYS_RST |-> st.mask_a == 8'h00 && st.mask_b == 8'h00 && st.dir == '0)
      else $error("mask or direction not zero after reset");
   a_load_wins: assert property (
      ld[0] |=> cq[0] == $past(BUS_WDATA[0]))
      else $error("processor load did not override cell");
   a_mask_blocks: assert property (
      cell_wr && BUS_ADDR == `PMI_OFS_CELL_A && st.mask_a[3] && !LA_CELL_PRE[3]
      && !LA_CELL_CLR[3] && !LA_CELL_CLK[3] && !CFG_EXTCLK[3] |=> $stable(cq[3]))
      else $error("masked cell changed on write");
   a_edge_no_level: assert property (
      !CFG_LEVEL_LD && BUS_SEL && !BUS_WR_N |-> ld == 16'h0000)
      else $error("edge mode loaded during strobe");
   a_level_loads: assert property (
      CFG_LEVEL_LD && BUS_SEL && !BUS_WR_N && BUS_ADDR == `PMI_OFS_CELL_B
      && st.mask_b == 8'h00 |=> cq[15:8] == $past(BUS_WDATA))
      else $error("level load failed");
   a_oe_from_dir: assert property (
      st.dir[5] |=> PIN_OE[5])
      else $error("direction bit did not enable driver");
   a_oe_dir_only: assert property (
      !CFG_OE_DEF[2] && !CFG_LOUT[2] |=> PIN_OE[2] == $past(st.dir[2]))
      else $error("direction alone not controlling pin");
   a_lout_drives: assert property (
      CFG_LOUT[20] && !CFG_OE_DEF[20] |=> PIN_OE[20])
      else $error("logic output not driven");
   a_addr_out: assert property (
      st.ctl[1] && st.dir[1] |=> PIN_OUT[1] == $past(st.alat[1]) && PIN_OE[1])
      else $error("address out not driven");
   a_mcu_io_out: assert property (
      !st.ctl[10] && !CFG_LOUT[10] |=> PIN_OUT[10] == $past(st.dout[10]))
      else $error("processor I/O pin not from data-out");
   a_cell_read: assert property (
      BUS_SEL && !BUS_RD_N && BUS_ADDR == `PMI_OFS_CELL_B |=> BUS_RDATA == $past(cq[15:8]))
      else $error("cell read-back mismatch");
   a_node_fb: assert property (
      !CFG_LOUT[4] && !CFG_LOUT[12] |=> LA_CELL_FB[4] == $past(cy[4]))
      else $error("internal node feedback lost");
   a_ctl_reset_zero: assert property (disable iff (1'b0)
      SYS_RST ##1 !SYS_RST |-> st.ctl == '0 && st.drv == '0)
      else $error("control or drive select not zero after reset");
   a_unmapped_zero: assert property (
      BUS_SEL && !BUS_RD_N && BUS_ADDR > `PMI_OFS_IMC_C |=> BUS_RDATA == `PMI_RST_BYTE)
      else $error("unmapped read not zero");
   a_idle_rdata: assert property (
      !(BUS_SEL && !BUS_RD_N) |=> BUS_RDATA == `PMI_RST_BYTE)
      else $error("read bus not released");
   a_clear_high: assert property (
      LA_CELL_CLR[0] && !ld[0] |=> !cq[0])
      else $error("clear did not reset cell");
   a_ext_clk_edge: assert property (
      CFG_EXTCLK[10] && ext_rise && !ld[10] && !LA_CELL_CLR[10] && !LA_CELL_PRE[10]
      |=> cq[10] == $past(LA_CELL_D[10]))
      else $error("external clock edge not taken");
   a_ecs_out: assert property (
      CFG_LOUT[25] |=> PIN_OUT[25] == $past(LA_ECS[0]))
      else $error("chip select not on pin");
   a_imc_pass: assert property (
      CFG_IMC_MODE[0] == IMC_PASS |=> LA_IMC_OUT[0] == $past(PIN_IN[0]))
      else $error("input cell pass-through lost");
   a_expand_a: assert property (
      CFG_TERMS[3:0] > 4'h9 |=> CELL_EXPAND[0])
      else $error("over-budget cell not flagged");

   c_level_load:   cover property (CFG_LEVEL_LD && ld[9] ##1 ld[9]);
   c_masked_write: cover property (wr_end && BUS_ADDR == `PMI_OFS_CELL_A && st.mask_a != 8'h00);
   c_addr_out:     cover property (st.ctl[0] && st.dir[0] ##1 PIN_OE[0]);
   c_expand:       cover property (CELL_EXPAND != 16'h0000);
   c_ecs_drive:    cover property (CFG_LOUT[26] && LA_ECS[1] ##1 PIN_OUT[26]);
endmodule
`default_nettype wire

// ### pmi_regs.svh
`ifndef PMI_REGS_SVH
`define PMI_REGS_SVH
// ****************************************************************
// Register window offsets
// ****************************************************************
`define PMI_OFS_DIN_A   8'h00
`define PMI_OFS_DIN_B   8'h01
`define PMI_OFS_DIN_C   8'h02
`define PMI_OFS_DIN_D   8'h03
`define PMI_OFS_DOUT_A  8'h04
`define PMI_OFS_DOUT_B  8'h05
`define PMI_OFS_DOUT_C  8'h06
`define PMI_OFS_DOUT_D  8'h07
`define PMI_OFS_CTL_A   8'h08
`define PMI_OFS_CTL_B   8'h09
`define PMI_OFS_DIR_A   8'h0A
`define PMI_OFS_DIR_B   8'h0B
`define PMI_OFS_DIR_C   8'h0C
`define PMI_OFS_DIR_D   8'h0D
`define PMI_OFS_DRV_A   8'h0E
`define PMI_OFS_DRV_B   8'h0F
`define PMI_OFS_DRV_C   8'h10
`define PMI_OFS_DRV_D   8'h11
`define PMI_OFS_CELL_A  8'h12
`define PMI_OFS_CELL_B  8'h13
`define PMI_OFS_MASK_A  8'h14
`define PMI_OFS_MASK_B  8'h15
`define PMI_OFS_IMC_A   8'h16
`define PMI_OFS_IMC_B   8'h17
`define PMI_OFS_IMC_C   8'h18
// ****************************************************************
// Reset values and cell term budgets
// ****************************************************************
`define PMI_RST_BYTE    8'h00
`define PMI_WR_IDLE     1'h1
`define PMI_NAT_A       3
`define PMI_BOR_A       6
`define PMI_NAT_B       4
`define PMI_BOR_B_LO    5
`define PMI_BOR_B_HI    6
`endif

// ### pmi_pkg.sv
`default_nettype none
package pmi_pkg;
   // Input cell modes.
   typedef enum logic [2:0]
   {
      IMC_PASS  = 3'h1,
      IMC_LATCH = 3'h2,
      IMC_REG   = 3'h4
   } pmi_imc_mode_t;
   // Output cell state.
   typedef struct packed {
      logic ff;
      logic ptc_q;
      logic y_d;
   } pmi_omc_st_t;
   // Port block state.
   typedef struct packed {
      logic [26:0] dout;
      logic [15:0] ctl;
      logic [26:0] dir;
      logic [26:0] drv;
      logic [7:0]  mask_a;
      logic [7:0]  mask_b;
      logic [7:0]  alat;
      logic        wr_n_q;
      logic        clk_q;
      logic [7:0]  rdata;
      logic [26:0] pin_out;
      logic [26:0] pin_oe;
      logic [26:0] drv_o;
      logic [15:0] fb;
      logic [23:0] imc;
      logic [15:0] xp;
   } pmi_top_st_t;
endpackage
`default_nettype wire

// ### pmi_omc.sv
`default_nettype none
module pmi_omc #(
   parameter int NATIVE = 3,
   parameter int BORROW = 6
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       ld,
   input  wire logic       ld_d,
   input  wire logic       d,
   input  wire logic       pt_clk,
   input  wire logic       ext_rise,
   input  wire logic       use_ext,
   input  wire logic       pre,
   input  wire logic       clr,
   input  wire logic       comb,
   input  wire logic [3:0] terms,
   output logic            q,
   output logic            y,
   output logic            xp
);
   import pmi_pkg::*;
   pmi_omc_st_t st;
   pmi_omc_st_t nx;
   logic        rise;
   logic        y_raw;
   // Next state: processor load first, then clear, preset and clock.
   always_comb
   begin
      nx        = st;
      nx.ptc_q  = pt_clk;
      rise      = use_ext ? ext_rise : (pt_clk & ~st.ptc_q);
      if (ld)
         nx.ff = ld_d;
      else if (clr)
         nx.ff = 1'b0;
      else if (pre)
         nx.ff = 1'b1;
      else if (rise)
         nx.ff = d;
      y_raw     = comb ? d : st.ff;
      nx.y_d    = y_raw;
      xp        = {1'b0, terms} > 5'(NATIVE + BORROW);
      q         = st.ff;
      y         = xp ? st.y_d : y_raw; // Expansion costs one extra stage.
   end
   // State register.
   always_ff @(posedge clk)
   begin
      if (rst)
         st <= '0;
      else
         st <= nx;
   end
endmodule
`default_nettype wire

// ### pmi_imc.sv
`default_nettype none
module pmi_imc #(
   parameter int W = 4
) (
   input  wire logic                           clk,
   input  wire logic                           rst,
   input  wire pmi_pkg::pmi_imc_mode_t [W-1:0] mode,
   input  wire logic                           pt,
   input  wire logic                           ale,
   input  wire logic                           use_ale,
   input  wire logic [W-1:0]                   pin,
   output logic      [W-1:0]                   o
);
   import pmi_pkg::*;
   typedef struct packed {
      logic [W-1:0] q;
      logic         en_q;
   } pmi_imc_st_t;
   pmi_imc_st_t st;
   pmi_imc_st_t nx;
   logic        en;
   logic        rise;
   // Latch follows while enabled; register takes the enable's rising edge.
   always_comb
   begin
      nx      = st;
      en      = use_ale ? ale : pt;
      rise    = en & ~st.en_q;
      nx.en_q = en;
      for (int i = 0; i < W; i++)
      begin
         case (mode[i])
            IMC_LATCH:
            begin
               if (en)
                  nx.q[i] = pin[i];
               o[i] = en ? pin[i] : st.q[i];
            end
            IMC_REG:
            begin
               if (rise)
                  nx.q[i] = pin[i];
               o[i] = st.q[i];
            end
            default:
               o[i] = pin[i];
         endcase
      end
   end
   // State register.
   always_ff @(posedge clk)
   begin
      if (rst)
         st <= '0;
      else
         st <= nx;
   end
endmodule
`default_nettype wire

// ### pmi_pin_model.sv
`default_nettype none
module pmi_pin_model (
   input  wire logic        clk,
   input  wire logic [26:0] pin_out,
   input  wire logic [26:0] pin_oe,
   input  wire logic [26:0] ext_val,
   input  wire logic [26:0] ext_en,
   output logic      [26:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [26:0] last_r = 27'h000_0000;
   // Resolves each pin: block driver, external driver, else a level that keeps moving.
   always_comb
   begin
      for (int i = 0; i < 27; i++)
      begin
         if (pin_oe[i])
            pin_in[i] = pin_out[i];
         else if (ext_en[i])
            pin_in[i] = ext_val[i];
         else
            pin_in[i] = ~last_r[i]; // Floating pin never looks settled.
      end
   end
   // Remembers the last level so a released pin toggles.
   always @(posedge clk)
   begin
      last_r <= pin_in;
   end
endmodule
`default_nettype wire

// ### test_pld_port_macrocell_io.sv
`default_nettype none
`include "pmi_regs.svh"
module test_pld_port_macrocell_io;
   timeunit 1ns;
   timeprecision 1ps;
   import pmi_pkg::*;
   logic clk = 0, rst = 1, sel = 0, wr_n = 1, rd_n = 1, ale = 0, lvl = 0, logic_array_clock_input = 0;
   logic [1:0] ecs = 0;
   logic [7:0] addr = 0, wdata = 0, alat = 0, rdata;
   logic [26:0] lout = 27'h0FF_0000, oe_def = 27'h000_0010, la_oe = 0;
   logic [26:0] ext_val = 0, ext_en = 0, pin_in, pin_out, pin_oe;
   logic [63:0] terms = 0;
   logic [15:0] pre = 0, clr = 0, cell_d = 0, cell_clk = 0, extclk = 0, fb, expand;
   logic [23:0] imc_out;
   pmi_imc_mode_t [23:0] imc_mode;
   int mismatches = 0;
   int checked = 0;
   // Clock at 25 MHz.
   always #20 clk = ~clk;
   pmi_top DUT (.CORE_CLK(clk), .SYS_RST(rst), .BUS_SEL(sel), .BUS_ADDR(addr),
      .BUS_WDATA(wdata), .BUS_WR_N(wr_n), .BUS_RD_N(rd_n), .BUS_ALE(ale),
      .BUS_ALAT(alat), .BUS_RDATA(rdata), .CFG_LEVEL_LD(lvl), .CFG_LOUT(lout),
      .CFG_OE_DEF(oe_def), .CFG_B_GRPB(8'h00), .CFG_COMB(16'h0000),
      .CFG_EXTCLK(extclk), .CFG_TERMS(terms), .CFG_IMC_MODE(imc_mode),
      .CFG_IMC_ALE(6'h00), .LA_CELL_D(cell_d), .LA_CELL_CLK(cell_clk),
      .LA_CELL_PRE(pre), .LA_CELL_CLR(clr), .LA_CLK_IN(logic_array_clock_input), .LA_OE(la_oe),
      .LA_ECS(ecs), .LA_IMC_PT(6'h00), .LA_CELL_FB(fb), .LA_IMC_OUT(imc_out),
      .CELL_EXPAND(expand), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
      .PIN_DRV());
   pmi_pin_model pins (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
      .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   // Prints the verdict and ends the run.
   task automatic report_and_stop();
      if (mismatches == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Compares one value and counts it.
   task automatic chk(input string n, input logic [26:0] s, input logic [26:0] e);
      checked++;
      if (s !== e)
      begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Write: strobe low over one edge, trailing edge at the next.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      sel = 1;
      addr = a;
      wdata = d;
      wr_n = 0;
      @(negedge clk);
      wr_n = 1;
      @(negedge clk);
      sel = 0;
      tick(3);
   endtask
   // Read held over two edges so the registered answer has landed.
   task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
      @(negedge clk);
      sel = 1;
      addr = a;
      rd_n = 0;
      tick(2);
      chk(n, {19'h0, rdata}, {19'h0, e});
      rd_n = 1;
      sel = 0;
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset();
      chk("oe_pwrup", pin_oe, lout & ~oe_def);
      chk("expand", {11'h0, expand}, 27'h000_2001);
      rchk("dir_a", `PMI_OFS_DIR_A, 8'h00);
      rchk("ctl_b", `PMI_OFS_CTL_B, 8'h00);
      rchk("drv_c", `PMI_OFS_DRV_C, 8'h00);
      rchk("mask_a", `PMI_OFS_MASK_A, 8'h00);
      rchk("mask_b", `PMI_OFS_MASK_B, 8'h00);
      rchk("unmapped", 8'h3F, 8'h00);
   endtask
   task automatic t_pio();
      ext_en[7:0] = 8'hFF;
      ext_val[7:0] = 8'h5A;
      tick(3);
      rchk("din_a", `PMI_OFS_DIN_A, 8'h5A);
      rchk("imc_a", `PMI_OFS_IMC_A, 8'h5A);
      chk("imc_out", {19'h0, imc_out[7:0]}, 27'h000_005A);
      ext_en[7:0] = 8'hF0;
      wr(`PMI_OFS_DOUT_A, 8'hC3);
      // Keep direction clear where the outside drives.
      wr(`PMI_OFS_DIR_A, 8'h0F);
      rchk("dir_a", `PMI_OFS_DIR_A, 8'h0F);
      rchk("dout_a", `PMI_OFS_DOUT_A, 8'hC3);
      chk("oe_dir", {19'h0, pin_oe[7:0]}, 27'h000_000F);
      chk("out_dout", {23'h0, pin_out[3:0]}, 27'h000_0003);
      la_oe[5:4] = 2'h3;
      ext_en[7:0] = 8'hC0;
      tick(3);
      chk("oe_term", {19'h0, pin_oe[7:0]}, 27'h000_001F);
   endtask
   task automatic t_addr();
      la_oe[5:4] = 2'h0;
      ext_en[7:0] = 8'h00;
      wr(`PMI_OFS_CTL_A, 8'hFF);
      wr(`PMI_OFS_DIR_A, 8'hFF);
      @(negedge clk);
      alat = 8'h3C;
      ale = 1;
      @(negedge clk);
      ale = 0;
      alat = 8'h99;
      tick(3);
      chk("addr_out", {19'h0, pin_out[7:0]}, 27'h000_003C);
      rchk("ctl_a", `PMI_OFS_CTL_A, 8'hFF);
      wr(`PMI_OFS_CTL_A, 8'h00);
      chk("mcu_io", {19'h0, pin_out[7:0]}, 27'h000_00C3);
   endtask
   task automatic t_cell();
      wr(`PMI_OFS_MASK_A, 8'h0F);
      wr(`PMI_OFS_CELL_A, 8'hFF);
      rchk("cell_a", `PMI_OFS_CELL_A, 8'hF0);
      rchk("mask_a", `PMI_OFS_MASK_A, 8'h0F);
      chk("fb_a", {19'h0, fb[7:0]}, 27'h000_00F0);
      wr(`PMI_OFS_CELL_B, 8'h81);
      rchk("cell_b", `PMI_OFS_CELL_B, 8'h81);
      chk("pin_cell", {19'h0, pin_out[23:16]}, 27'h000_0081);
      @(negedge clk);
      pre[9] = 1;
      @(negedge clk);
      pre[9] = 0;
      tick(2);
      rchk("preset", `PMI_OFS_CELL_B, 8'h83);
   endtask
   // Level load: strobe low over three edges, feedback checked before it rises.
   task automatic lvl_wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
      @(negedge clk);
      sel = 1;
      addr = a;
      wdata = d;
      wr_n = 0;
      tick(3);
      chk("fb_level", {19'h0, (a == `PMI_OFS_CELL_A) ? fb[7:0] : fb[15:8]}, {19'h0, e});
      wr_n = 1;
      @(negedge clk);
      sel = 0;
      tick(2);
   endtask
   task automatic t_logic();
      @(negedge clk);
      lvl = 1;
      lvl_wr(`PMI_OFS_CELL_B, 8'h5A, 8'h5A);
      rchk("cell_lvl", `PMI_OFS_CELL_B, 8'h5A);
      wr(`PMI_OFS_MASK_A, 8'h00);
      @(negedge clk);
      clr[7:0] = 8'hFF;
      lvl_wr(`PMI_OFS_CELL_A, 8'hA5, 8'hA5);
      clr[7:0] = 8'h00;
      rchk("cleared", `PMI_OFS_CELL_A, 8'h00);
      extclk[10] = 1;
      cell_d[11:10] = 2'h1;
      logic_array_clock_input = 1;
      cell_clk[11] = 1;
      @(negedge clk);
      logic_array_clock_input = 0;
      cell_clk[11] = 0;
      tick(2);
      rchk("clocked", `PMI_OFS_CELL_B, 8'h56);
      lvl = 0;
      lout[26:25] = 2'h3;
      ecs = 2'h2;
      tick(2);
      chk("ecs_out", {24'h0, pin_out[26:24]}, 27'h000_0004);
      chk("ecs_oe", {25'h0, pin_oe[26:25]}, 27'h000_0003);
   endtask
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial
   begin
      for (int i = 0; i < 24; i++)
         imc_mode[i] = IMC_PASS;
      terms[3:0] = 4'hA;
      terms[35:32] = 4'h9;
      terms[51:48] = 4'hA;
      terms[55:52] = 4'hB;
      repeat (6) @(posedge clk);
      @(negedge clk);
      rst = 0;
      tick(3);
      t_reset();
      t_pio();
      t_addr();
      t_cell();
      t_logic();
      report_and_stop();
   end
   // Cuts a hang short.
   initial
   begin
      repeat (20000) @(posedge clk);
      mismatches++;
      report_and_stop();
   end
endmodule
`default_nettype wire
